// ==== rtl/irq_logic_cfg.svh ====
// Register offsets, bit positions, reset values and timing counts
// for the interrupt logic. Definitions only; included by bare name.
`ifndef IRQ_LOGIC_CFG_SVH
`define IRQ_LOGIC_CFG_SVH

// Word offsets on the register bus (byte addresses)
`define OFS_IRQ_CONTROL 4'h0
`define OFS_IRQ_STATUS 4'h4
`define OFS_IRQ_CLEAR 4'h8
`define OFS_IRQ_ENABLE 4'hC

// Bit positions inside the control register
`define BIT_CHANGE_FLAG 0
`define BIT_EXT_FLAG 1
`define BIT_TIMER_FLAG 2
`define BIT_CHANGE_EN 3
`define BIT_EXT_EN 4
`define BIT_TIMER_EN 5
`define BIT_GLOBAL_EN 7

// Reset values
`define RST_FLAGS 3'h0
`define RST_ENABLES 3'h0
`define RST_GLOBAL 1'h0

// Vector loaded into the program counter when a request is taken
`define IRQ_VECTOR 13'h0004

// Pin synchroniser depth in clock cycles
`define SYNC_STAGES 2

`endif

// ==== rtl/irq_logic_pkg.sv ====
// Types shared by the interrupt logic and whoever instantiates it.
// Assumes classic Wishbone with 32-bit data and byte selects.
package irq_logic_pkg;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    // Answer back to the master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // Per-source bit vector: change, external, timer
    typedef struct packed {
        logic timer;
        logic ext;
        logic change;
    } src_bits_t;

    // Request signals towards the core's program counter and stack
    typedef struct packed {
        logic take;
        logic push_return;
        logic force_nop;
        logic [12:0] vector_addr;
    } core_req_t;

endpackage : irq_logic_pkg

// ==== rtl/mcu_interrupt_logic.sv ====
// Interrupt logic of a small 8-bit controller: three sources, per-source
// flags and enables, a global enable, vectoring towards the core.
// Assumes one 100 MHz clock, synchronous reset, a classic Wishbone master
// and a core that pushes the return address when told to.
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`include "irq_logic_cfg.svh"

module mcu_interrupt_logic
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire irq_logic_pkg::wb_req_t i_wb,
    output irq_logic_pkg::wb_rsp_t o_wb,
    input wire logic i_ext_irq_pin,
    input wire logic [3:0] i_upper_change_pins,
    input wire logic i_timer0_overflow,
    input wire logic i_return_from_irq_instr,
    input wire logic i_global_clear_instr,
    output irq_logic_pkg::core_req_t o_core,
    output logic o_irq
);
    import irq_logic_pkg::*;

    // Pin synchronisers; stage one feeds stage two only
    logic [`SYNC_STAGES-1:0] ext_sync_r;
    logic [`SYNC_STAGES-1:0] ext_sync_nxt;
    logic [3:0] chg_s1_r;
    logic [3:0] chg_s1_nxt;
    logic [3:0] chg_s2_r;
    logic [3:0] chg_s2_nxt;
    // Last seen levels, for edge and change detection
    logic ext_last_r;
    logic ext_last_nxt;
    logic [3:0] chg_last_r;
    logic [3:0] chg_last_nxt;
    // Detected events this cycle
    src_bits_t event_now;

    // Synchroniser next values
    always_comb
    begin
        ext_sync_nxt = {ext_sync_r[0], i_ext_irq_pin};
        chg_s1_nxt = i_upper_change_pins;
        chg_s2_nxt = chg_s1_r;
        ext_last_nxt = ext_sync_r[1];
        chg_last_nxt = chg_s2_r;
    end

    // Synchroniser registers; left out of reset on purpose, so they track
    // the pins through reset and no false edge or change follows its release
    always_ff @(posedge i_clock)
    begin
        ext_sync_r <= ext_sync_nxt;
        chg_s1_r <= chg_s1_nxt;
        chg_s2_r <= chg_s2_nxt;
        ext_last_r <= ext_last_nxt;
        chg_last_r <= chg_last_nxt;
    end

    // Event detection: rising pin edge, any change, timer pulse
    always_comb
    begin
        event_now.ext = ext_sync_r[1] & ~ext_last_r;
        event_now.change = |(chg_s2_r ^ chg_last_r);
        event_now.timer = i_timer0_overflow;
    end

    // Control state
    src_bits_t flags_r;
    src_bits_t flags_nxt;
    src_bits_t enables_r;
    src_bits_t enables_nxt;
    logic global_r;
    logic global_nxt;
    // One-cycle hold-off after the global enable is cleared
    logic block_r;
    logic block_nxt;
    // Bus decode
    logic bus_hit;
    logic wr_ctrl;
    logic wr_clear;
    logic wr_enable;
    logic take;
    logic global_cleared;

    // Bus access decode; byte lane 0 carries every field
    always_comb
    begin
        bus_hit = i_wb.cyc & i_wb.stb & ~o_wb.ack;
        wr_ctrl = bus_hit & i_wb.we & i_wb.sel[0] & (i_wb.adr == `OFS_IRQ_CONTROL);
        wr_clear = bus_hit & i_wb.we & i_wb.sel[0] & (i_wb.adr == `OFS_IRQ_CLEAR);
        wr_enable = bus_hit & i_wb.we & i_wb.sel[0] & (i_wb.adr == `OFS_IRQ_ENABLE);
    end

    // Request taken: global, pending enabled source, not held off
    always_comb
    begin
        // Software or an instruction dropping the global enable
        global_cleared = (wr_ctrl & ~i_wb.dat[`BIT_GLOBAL_EN] & global_r)
            | i_global_clear_instr;
        o_irq = global_r & |(flags_r & enables_r);
        // A clear in this cycle wins, or take and no-op would meet at the core
        take = o_irq & ~block_r & ~o_core.take & ~global_cleared;
    end

    // Next control state
    always_comb
    begin
        flags_nxt = flags_r;
        enables_nxt = enables_r;
        global_nxt = global_r;
        block_nxt = global_cleared;
        if (wr_ctrl)
        begin
            // Software owns the flags; it may clear them here
            flags_nxt = src_bits_t'(i_wb.dat[`BIT_TIMER_FLAG:`BIT_CHANGE_FLAG]);
            enables_nxt = src_bits_t'(i_wb.dat[`BIT_TIMER_EN:`BIT_CHANGE_EN]);
        end
        if (wr_clear)
        begin
            flags_nxt = flags_nxt & ~src_bits_t'(i_wb.dat[2:0]);
        end
        if (wr_enable)
        begin
            enables_nxt = src_bits_t'(i_wb.dat[2:0]);
        end
        // Events win over a clear in the same cycle
        flags_nxt = flags_nxt | event_now;
        // Global enable: take beats return beats software
        if (take)
        begin
            global_nxt = 1'b0;
        end
        else if (i_return_from_irq_instr)
        begin
            global_nxt = 1'b1;
        end
        else if (i_global_clear_instr)
        begin
            global_nxt = 1'b0;
        end
        else if (wr_ctrl)
        begin
            global_nxt = i_wb.dat[`BIT_GLOBAL_EN];
        end
    end

    // Control registers
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            flags_r <= `RST_FLAGS;
            enables_r <= `RST_ENABLES;
            global_r <= `RST_GLOBAL;
            block_r <= 1'b0;
        end
        else
        begin
            flags_r <= flags_nxt;
            enables_r <= enables_nxt;
            global_r <= global_nxt;
            block_r <= block_nxt;
        end
    end

    // Core-facing outputs, registered so they line up with the take
    core_req_t core_nxt;

    // Core request next values
    always_comb
    begin
        core_nxt.take = take;
        core_nxt.push_return = take;
        core_nxt.force_nop = global_cleared;
        core_nxt.vector_addr = `IRQ_VECTOR;
    end

    // Core request register
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_core <= '0;
        end
        else
        begin
            o_core <= core_nxt;
        end
    end

    // Bus answer: one wait state, unmapped reads return zero
    wb_rsp_t rsp_nxt;

    // Read mux and acknowledge
    always_comb
    begin
        rsp_nxt.ack = bus_hit;
        rsp_nxt.dat = 32'h0000_0000;
        if (bus_hit & ~i_wb.we)
        begin
            case (i_wb.adr)
                `OFS_IRQ_CONTROL:
                begin
                    rsp_nxt.dat[`BIT_GLOBAL_EN] = global_r;
                    rsp_nxt.dat[`BIT_TIMER_EN:`BIT_CHANGE_EN] = enables_r;
                    rsp_nxt.dat[`BIT_TIMER_FLAG:`BIT_CHANGE_FLAG] = flags_r;
                end
                `OFS_IRQ_STATUS:
                begin
                    rsp_nxt.dat[2:0] = flags_r;
                end
                `OFS_IRQ_ENABLE:
                begin
                    rsp_nxt.dat[2:0] = enables_r;
                end
                default:
                begin
                    // Clear register is write-only; reads zero
                    rsp_nxt.dat = 32'h0000_0000;
                end
            endcase
        end
    end

    // Bus answer register
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_wb <= '0;
        end
        else
        begin
            o_wb <= rsp_nxt;
        end
    end

    // Checks on the control path
    AST_GLOBAL_RESET: assert property (@(posedge i_clock)
        $past(i_rst) |-> !global_r)
        else $error("global enable not clear after reset");

    AST_TAKE_CLEARS: assert property (@(posedge i_clock) disable iff (i_rst)
        take |=> !global_r ##0 o_core.take ##0 o_core.push_return)
        else $error("take did not clear global and push");

    AST_VECTOR: assert property (@(posedge i_clock) disable iff (i_rst)
        o_core.take |-> o_core.vector_addr == 13'h0004)
        else $error("wrong vector address");

    AST_GATING: assert property (@(posedge i_clock) disable iff (i_rst)
        o_core.take |-> $past(global_r) && |($past(flags_r) & $past(enables_r)))
        else $error("take without enabled pending source");

    AST_FLAG_SET: assert property (@(posedge i_clock) disable iff (i_rst)
        event_now.ext |=> flags_r.ext)
        else $error("external flag not set by event");

    AST_RETURN: assert property (@(posedge i_clock) disable iff (i_rst)
        i_return_from_irq_instr && !take |=> global_r)
        else $error("return did not set global enable");

    AST_HOLD_OFF: assert property (@(posedge i_clock) disable iff (i_rst)
        global_cleared |-> !take ##1 o_core.force_nop && !take)
        else $error("no hold-off after global clear");

    AST_STICKY: assert property (@(posedge i_clock) disable iff (i_rst)
        flags_r.timer && !wr_ctrl && !wr_clear |=> flags_r.timer)
        else $error("timer flag dropped without software");

    AST_PENDING: assert property (@(posedge i_clock) disable iff (i_rst)
        block_r && flags_r.ext && enables_r.ext && global_r && !wr_ctrl && !wr_clear
        |=> ##[0:1] o_core.take)
        else $error("held-off request not serviced");

    COV_TAKE: cover property (@(posedge i_clock) disable iff (i_rst) o_core.take);
    COV_BLOCKED: cover property (@(posedge i_clock) disable iff (i_rst)
        block_r && o_irq);
    COV_RETURN: cover property (@(posedge i_clock) disable iff (i_rst)
        o_core.take ##[1:20] i_return_from_irq_instr);

endmodule : mcu_interrupt_logic

// ==== test/core_model.sv ====
// Core side model: vector entry and return-stack depth.
// Assumes take and push_return come as one-cycle pulses.
`timescale 1ns/10ps

module core_model
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire irq_logic_pkg::core_req_t i_core,
    output logic [12:0] o_entry,
    output logic [3:0] o_depth
);
    import irq_logic_pkg::*;

    // Vector and stack, loaded only when a request is taken
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_entry <= '0;
            o_depth <= '0;
        end
        else if (i_core.take && !i_core.force_nop)
        begin
            o_entry <= i_core.vector_addr;
            o_depth <= o_depth + {3'h0, i_core.push_return};
        end
    end
endmodule : core_model

// ==== test/mcu_interrupt_logic_tb.sv ====
// Bench for the interrupt logic: bus, event pins, core link.
// Assumes the design's registered one-wait-state bus answer.
`timescale 1ns/10ps
`include "irq_logic_cfg.svh"

module mcu_interrupt_logic_tb;
    import irq_logic_pkg::*;

    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    wb_req_t wb_r = '0;
    wb_rsp_t o_wb;
    core_req_t o_core;
    logic o_irq;
    logic pin = 1'b0;
    logic [3:0] chg = 4'h0;
    logic tmr = 1'b0;
    logic rti = 1'b0;
    logic gcl = 1'b0;
    logic [12:0] entry;
    logic [3:0] depth;
    logic [31:0] seed = 32'h0000_C854;
    logic [31:0] q;
    logic [31:0] r;
    int n_errors = 0;
    int num_checks = 0;
    int takes = 0;
    int nops = 0;
    int lat;

    mcu_interrupt_logic i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_wb(wb_r), .o_wb(o_wb),
        .i_ext_irq_pin(pin), .i_upper_change_pins(chg), .i_timer0_overflow(tmr),
        .i_return_from_irq_instr(rti), .i_global_clear_instr(gcl), .o_core(o_core),
        .o_irq(o_irq));
    core_model i_core (.i_clock(i_clock), .i_rst(i_rst), .i_core(o_core), .o_entry(entry),
        .o_depth(depth));

    // Clock at 100 MHz
    initial
    begin
        forever #5 i_clock = ~i_clock;
    end

    // Xorshift source, fixed seed
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Expected control word from flags, enables and global bit
    function automatic logic [31:0] ctl(logic [2:0] f, logic [2:0] e, logic g);
        return {24'h0, g, 1'b0, e, f};
    endfunction : ctl

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    // One classic cycle; ack and read data taken at the same rising edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clock);
        wb_r <= '{1'b1, 1'b1, w, a, 4'hF, d};
        // Only the watchdog ends a wait that never sees ack
        do
        begin
            @(posedge i_clock);
        end
        while (o_wb.ack !== 1'b1);
        q = o_wb.dat;
        wb_r <= '0;
    endtask : wb

    // One-cycle pulse: 0 timer, 1 return, 2 global clear
    task automatic pulse(input int k);
        @(posedge i_clock);
        tmr <= (k == 0);
        rti <= (k == 1);
        gcl <= (k == 2);
        @(posedge i_clock);
        {tmr, rti, gcl} <= 3'h0;
    endtask : pulse

    // Core link watch, sampled mid-cycle where settled
    always @(negedge i_clock)
    begin
        takes += (o_core.take === 1'b1);
        nops += (o_core.force_nop === 1'b1);
    end

    task automatic finish_test();
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    initial
    begin
        #200000;
        n_errors++;
        finish_test();
    end

    initial
    begin
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        wb(0, `OFS_IRQ_CONTROL, 0);
        chk(q, 0);
        r = rnd();
        wb(1, `OFS_IRQ_ENABLE, r);
        wb(0, `OFS_IRQ_ENABLE, 0);
        chk(q, r & 32'h7);
        wb(1, `OFS_IRQ_ENABLE, 0);
        pulse(0);
        wb(0, `OFS_IRQ_STATUS, 0);
        chk(q, 32'h4);
        wb(1, `OFS_IRQ_CONTROL, ctl(3'h4, 3'h0, 1'b1));
        repeat (3) @(posedge i_clock);
        chk({31'h0, o_irq}, 32'h0);
        chk(takes, 0);
        wb(1, `OFS_IRQ_CONTROL, ctl(3'h4, 3'h4, 1'b1));
        repeat (3) @(posedge i_clock);
        chk(takes, 1);
        chk({19'h0, entry}, `IRQ_VECTOR);
        wb(0, `OFS_IRQ_CONTROL, 0);
        chk(q, ctl(3'h4, 3'h4, 1'b0));
        wb(1, `OFS_IRQ_CLEAR, 32'h4);
        wb(0, `OFS_IRQ_STATUS, 0);
        chk(q, 0);
        pulse(1);
        wb(0, `OFS_IRQ_CONTROL, 0);
        chk(q, ctl(3'h0, 3'h4, 1'b1));
        wb(1, `OFS_IRQ_CONTROL, ctl(3'h0, 3'h6, 1'b1));
        @(posedge i_clock);
        pin <= 1'b1;
        lat = 0;
        do
        begin
            @(posedge i_clock);
            lat++;
        end
        while (o_core.take !== 1'b1 && lat < 20);
        // Take is seen one edge after the edge that launches it
        chk((lat - 1) >= 3 && (lat - 1) <= 4, 1);
        wb(0, `OFS_IRQ_STATUS, 0);
        chk(q, 32'h2);
        wb(1, `OFS_IRQ_CLEAR, 32'h2);
        pulse(1);
        pulse(2);
        @(posedge i_clock);
        chk(nops, 1);
        wb(1, `OFS_IRQ_CONTROL, ctl(3'h0, 3'h7, 1'b0));
        r = rnd();
        chg <= chg ^ (r[3:0] | 4'h1);
        repeat (6) @(posedge i_clock);
        wb(0, `OFS_IRQ_STATUS, 0);
        chk(q, 32'h1);
        chk(takes, 2);
        chk({31'h0, o_irq}, 32'h0);
        pulse(1);
        repeat (3) @(posedge i_clock);
        chk(takes, 3);
        chk({28'h0, depth}, 3);
        wb(0, 4'h6, 0);
        chk(q, 0);
        pulse(1);
        i_rst <= 1'b1;
        @(posedge i_clock);
        i_rst <= 1'b0;
        wb(0, `OFS_IRQ_CONTROL, 0);
        chk(q, 32'h0);
        finish_test();
    end
endmodule : mcu_interrupt_logic_tb
